/* rtl/hs_timer_pkg.sv */
/*
  Shared constants and types of the high speed timer: register
  index map, field positions, reset values and compare output codes.
  Assumes an 8-bit register port with a 4-bit register index.
*/
package hs_timer_pkg;
  localparam int CNT_W = 10;
  localparam int PRESC_MIN_W = 14;
  typedef logic [CNT_W-1:0] cnt_t;

  // Register index map
  localparam logic [3:0] A_CNT_LO = 4'h0;
  localparam logic [3:0] A_HIGH_BUF = 4'h1;
  localparam logic [3:0] A_CMP_A = 4'h2;
  localparam logic [3:0] A_CMP_B = 4'h3;
  localparam logic [3:0] A_TOP = 4'h4;
  localparam logic [3:0] A_CMP_D = 4'h5;
  localparam logic [3:0] A_CTRL_A = 4'h6;
  localparam logic [3:0] A_CTRL_B = 4'h7;
  localparam logic [3:0] A_COM = 4'h8;
  localparam logic [3:0] A_DEAD = 4'h9;
  localparam logic [3:0] A_FLAGS = 4'hA;
  localparam logic [3:0] A_IRQ_EN = 4'hB;
  localparam logic [3:0] A_PLL = 4'hC;

  // Field positions
  localparam int CS_LSB = 0;
  localparam int DTPS_LSB = 4;
  localparam int WGM_BIT = 6;
  localparam int INV_BIT = 7;
  localparam int PWM_EN_LSB = 0;
  localparam int FORCE_LSB = 3;
  localparam int DT_HI_LSB = 4;
  localparam int DT_LO_LSB = 0;
  localparam int PLL_TM_LSB = 0;
  localparam int PLL_LOCK_BIT = 7;

  // Values
  localparam cnt_t TOP_RST = 10'h0FF;
  localparam cnt_t CNT_MAX = 10'h3FF;
  localparam cnt_t CNT_ZERO = 10'h000;
  localparam cnt_t CNT_ONE = 10'h001;
  localparam logic [3:0] CS_STOP = 4'h0;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [3:0] rise;
    logic [3:0] fall;
    logic invert;
  } dt_cfg_s;
endpackage

/* rtl/hs_tick_gen.sv */
/*
  Timer tick prescaler: selection zero stops, selection n ticks
  once every 2^(n-1) clocks. Assumes one clock and a clock enable.
*/
`timescale 1ns/1ps
module hs_tick_gen #(
  parameter int PRESC_W = 14
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [3:0] clock_select_i,
  output logic tick_o
);
  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] mask;

  if (PRESC_W < hs_timer_pkg::PRESC_MIN_W) begin : g_chk
    $error("prescaler narrower than largest division");
  end

  // Low bits that must be all ones for a tick
  always_comb begin
    for (int i = 0; i < PRESC_W; i++) begin
      mask[i] = (i + 1) < int'(clock_select_i);
    end
  end

  // Divider restarts while stopped so the first tick is clean
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      presc <= '0;
    end else if (ce_i) begin
      if (clock_select_i == hs_timer_pkg::CS_STOP) begin
        presc <= '0;
      end else begin
        presc <= presc + PRESC_W'(1);
      end
    end
  end

  assign tick_o = ce_i && (clock_select_i != hs_timer_pkg::CS_STOP) &&
                  ((presc & mask) == mask);
endmodule // hs_tick_gen

/* rtl/hs_dead_time.sv */
/*
  Dead time generator for one channel: turns the waveform into a
  non-overlapping complementary pair. Assumes the timer tick and a
  prescaled dead time tick from the same clock.
*/
`timescale 1ns/1ps
module hs_dead_time (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic dt_tick_i,
  input wire logic enable_i,
  input wire logic wave_i,
  input wire hs_timer_pkg::dt_cfg_s cfg_i,
  output logic oc_true_o,
  output logic oc_comp_o
);
  logic wave_d;
  logic [3:0] dcnt;
  logic [3:0] next_dcnt;
  logic out_t;
  logic out_c;
  logic edge_seen;

  assign edge_seen = wave_i != wave_d;
  assign next_dcnt = edge_seen ? (wave_i ? cfg_i.rise : cfg_i.fall) : dcnt;

  // Both outputs low while counting; rising output waits for zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wave_d <= 1'b0;
      dcnt <= 4'h0;
      out_t <= 1'b0;
      out_c <= 1'b0;
    end else if (ce_i && tick_i) begin
      wave_d <= wave_i;
      if (!enable_i) begin
        out_t <= wave_i;
        out_c <= 1'b0;
        dcnt <= 4'h0;
      end else if (next_dcnt == 4'h0) begin
        out_t <= wave_i;
        out_c <= ~wave_i;
        dcnt <= 4'h0;
      end else begin
        out_t <= 1'b0;
        out_c <= 1'b0;
        dcnt <= dt_tick_i ? next_dcnt - 4'h1 : next_dcnt;
      end
    end
  end

  assign oc_true_o = out_t ^ (cfg_i.invert && enable_i);
  assign oc_comp_o = out_c ^ (cfg_i.invert && enable_i);
endmodule // hs_dead_time

/* rtl/hs_timer.sv */
/*
  Ten-bit high speed timer/counter: counter with stop, PWM and
  up-down sequences, three compare channels with flags, double
  buffered compare values and dead time output pairs.
  Assumes a CPU master on the plain 8-bit register port, one clock,
  and one interrupt service pulse per flag from the CPU side.
*/
// Operation
// - Zero count raises bottom indication
// - All ones count means maximum
// - Top from register C, resets 255
// - Tick clears, increments or decrements counter
// - Select zero stops; counter stays accessible
// - Counter write beats count operations
// - Match sets flag one tick later
// - Flag requests interrupt; service or one clears
// - PWM double buffers; normal writes direct
// - Reads return most recently written value
// - Force updates waveform, no flag, no reload
// - Counter write blocks next tick's matches
// - Mode switch keeps output level
// - Output mode changes act at once
// - Per channel complementary dead time pair
// - Dead time prescale 1, 2, 4, 8
// - Edge loads nibble, delays rising output
// - High nibble true, low complementary
// - Outputs lag waveform one tick minimum
// - Inversion bit inverts both pair outputs of channels with dead time on
// - Low byte access uses shared high buffer
// - Normal mode counts zero to top
`timescale 1ns/1ps
module hs_timer (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire hs_timer_pkg::bus_req_s bus_req_i,
  output logic [7:0] rdata_o,
  input wire logic [3:0] int_ack_i,
  input wire logic pll_lock_i,
  output logic [3:0] irq_o,
  output logic [2:0] oc_true_o,
  output logic [2:0] oc_comp_o,
  output logic bottom_o,
  output logic max_o
);
  // Write strobe decode for one register
  function automatic logic wr_hit(hs_timer_pkg::bus_req_s r,
                                  logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Register index of compare slot k; slot 2 is the top
  function automatic logic [3:0] slot_addr(int k);
    case (k)
      0: return hs_timer_pkg::A_CMP_A;
      1: return hs_timer_pkg::A_CMP_B;
      2: return hs_timer_pkg::A_TOP;
      default: return hs_timer_pkg::A_CMP_D;
    endcase
  endfunction

  // Waveform level after a non-PWM match
  function automatic logic com_level(logic [1:0] com, logic cur);
    case (com)
      hs_timer_pkg::COM_TOGGLE: return ~cur;
      hs_timer_pkg::COM_CLEAR: return 1'b0;
      hs_timer_pkg::COM_SET: return 1'b1;
      default: return cur;
    endcase
  endfunction

  logic [3:0] clock_select_field;
  logic [1:0] dead_time_prescale;
  logic waveform_gen_bit;
  logic pwm_inversion_bit;
  logic [2:0] channel_pwm_enable;
  logic [5:0] compare_output_mode;
  logic [7:0] dead_time_reg;
  logic [3:0] irq_enable;
  logic [1:0] fast_postscaler_field;
  logic [1:0] shared_high_byte_buffer;
  hs_timer_pkg::cnt_t count_value;
  hs_timer_pkg::cnt_t next_count;
  hs_timer_pkg::cnt_t compare_value_reg [4];
  hs_timer_pkg::cnt_t compare_active [4];
  hs_timer_pkg::cnt_t top_value_reg;
  hs_timer_pkg::cnt_t wr_word;
  hs_timer_pkg::dir_e count_dir;
  hs_timer_pkg::dir_e next_dir;
  hs_timer_pkg::dt_cfg_s dt_cfg;
  logic [3:0] flags;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic match_block;
  logic timer_tick;
  logic [2:0] waveform_output;
  logic [2:0] force_compare_strobe;
  logic [2:0] cmp_hit;
  logic [2:0] dt_div;
  logic [2:0] dt_mask;
  logic dt_tick;
  logic lock_s1;
  logic lock_s2;
  logic lock_s3;
  logic pll_lock_flag;
  logic cnt_wr;
  logic pwm_mode;
  logic up_down;
  logic at_top;
  logic at_zero;
  logic ovf_event;
  logic buf_update;
  logic [7:0] rd_val;
  logic [1:0] rd_hi;
  logic rd_latch;

  assign wr_word = {shared_high_byte_buffer, bus_req_i.wdata};
  assign cnt_wr = wr_hit(bus_req_i, hs_timer_pkg::A_CNT_LO);
  assign pwm_mode = |channel_pwm_enable;
  assign up_down = pwm_mode && waveform_gen_bit;
  assign top_value_reg = compare_active[2];
  assign at_top = count_value == top_value_reg;
  assign at_zero = count_value == hs_timer_pkg::CNT_ZERO;
  assign bottom_o = at_zero;
  assign max_o = count_value == hs_timer_pkg::CNT_MAX;

  hs_tick_gen #(
    .PRESC_W(hs_timer_pkg::PRESC_MIN_W)
  ) u_tick (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .clock_select_i(clock_select_field),
    .tick_o(timer_tick)
  );

  // Control registers; force bits are strobes and not stored
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clock_select_field <= hs_timer_pkg::CS_STOP;
      dead_time_prescale <= 2'h0;
      waveform_gen_bit <= 1'b0;
      pwm_inversion_bit <= 1'b0;
      channel_pwm_enable <= 3'h0;
      compare_output_mode <= 6'h00;
      dead_time_reg <= 8'h00;
      irq_enable <= 4'h0;
      fast_postscaler_field <= 2'h0;
    end else if (ce_i) begin
      if (wr_hit(bus_req_i, hs_timer_pkg::A_CTRL_A)) begin
        clock_select_field <= bus_req_i.wdata[hs_timer_pkg::CS_LSB +: 4];
        dead_time_prescale <= bus_req_i.wdata[hs_timer_pkg::DTPS_LSB +: 2];
        waveform_gen_bit <= bus_req_i.wdata[hs_timer_pkg::WGM_BIT];
        pwm_inversion_bit <= bus_req_i.wdata[hs_timer_pkg::INV_BIT];
      end
      if (wr_hit(bus_req_i, hs_timer_pkg::A_CTRL_B)) begin
        channel_pwm_enable <=
          bus_req_i.wdata[hs_timer_pkg::PWM_EN_LSB +: 3];
      end
      if (wr_hit(bus_req_i, hs_timer_pkg::A_COM)) begin
        compare_output_mode <= bus_req_i.wdata[5:0];
      end
      if (wr_hit(bus_req_i, hs_timer_pkg::A_DEAD)) begin
        dead_time_reg <= bus_req_i.wdata;
      end
      if (wr_hit(bus_req_i, hs_timer_pkg::A_IRQ_EN)) begin
        irq_enable <= bus_req_i.wdata[3:0];
      end
      if (wr_hit(bus_req_i, hs_timer_pkg::A_PLL)) begin
        fast_postscaler_field <=
          bus_req_i.wdata[hs_timer_pkg::PLL_TM_LSB +: 2];
      end
    end
  end

  assign force_compare_strobe =
    (wr_hit(bus_req_i, hs_timer_pkg::A_CTRL_B) && !pwm_mode) ?
    bus_req_i.wdata[hs_timer_pkg::FORCE_LSB +: 3] : 3'h0;

  // Lock pin is asynchronous: three stages, change once 2 and 3 agree
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_s3 <= 1'b0;
      pll_lock_flag <= 1'b0;
    end else if (ce_i) begin
      lock_s1 <= pll_lock_i;
      lock_s2 <= lock_s1;
      lock_s3 <= lock_s2;
      if (lock_s2 == lock_s3) begin
        pll_lock_flag <= lock_s3;
      end
    end
  end

  // Next count; a write wins over whatever the tick would do
  always_comb begin
    next_count = count_value;
    next_dir = count_dir;
    if (cnt_wr) begin
      next_count = wr_word;
    end else if (timer_tick) begin
      if (!up_down) begin
        next_dir = hs_timer_pkg::DIR_UP;
        next_count = at_top ? hs_timer_pkg::CNT_ZERO :
                     count_value + hs_timer_pkg::CNT_ONE;
      end else if (count_dir == hs_timer_pkg::DIR_UP) begin
        if (at_top) begin
          next_dir = hs_timer_pkg::DIR_DOWN;
          next_count = count_value - hs_timer_pkg::CNT_ONE;
        end else begin
          next_count = count_value + hs_timer_pkg::CNT_ONE;
        end
      end else begin
        if (at_zero) begin
          next_dir = hs_timer_pkg::DIR_UP;
          next_count = count_value + hs_timer_pkg::CNT_ONE;
        end else begin
          next_count = count_value - hs_timer_pkg::CNT_ONE;
        end
      end
    end
  end

  // Counter and direction
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      count_value <= hs_timer_pkg::CNT_ZERO;
      count_dir <= hs_timer_pkg::DIR_UP;
    end else if (ce_i) begin
      count_value <= next_count;
      count_dir <= next_dir;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      match_block <= 1'b0;
    end else if (ce_i) begin
      if (cnt_wr) begin
        match_block <= 1'b1;
      end else if (timer_tick) begin
        match_block <= 1'b0;
      end
    end
  end

  assign buf_update = timer_tick && pwm_mode && (up_down ? at_zero : at_top);

  // Compare slots: written copy and the copy the comparators use
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int k = 0; k < 4; k++) begin
        compare_value_reg[k] <= (k == 2) ? hs_timer_pkg::TOP_RST :
                                hs_timer_pkg::CNT_ZERO;
        compare_active[k] <= (k == 2) ? hs_timer_pkg::TOP_RST :
                             hs_timer_pkg::CNT_ZERO;
      end
    end else if (ce_i) begin
      for (int k = 0; k < 4; k++) begin
        if (buf_update) begin
          compare_active[k] <= compare_value_reg[k];
        end
        if (wr_hit(bus_req_i, slot_addr(k))) begin
          compare_value_reg[k] <= wr_word;
          if (!pwm_mode) begin
            compare_active[k] <= wr_word;
          end
        end
      end
    end
  end

  assign ovf_event = up_down ?
    (count_dir == hs_timer_pkg::DIR_DOWN && at_zero) : at_top;
  assign flag_set[0] = timer_tick && !cnt_wr && ovf_event;
  assign flag_set[3:1] = cmp_hit;
  assign flag_clr = int_ack_i |
    (wr_hit(bus_req_i, hs_timer_pkg::A_FLAGS) ? bus_req_i.wdata[3:0] : 4'h0);

  // Clear by service or one; a same-cycle set wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flags <= 4'h0;
    end else if (ce_i) begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  assign irq_o = flags & irq_enable;

  assign dt_mask = 3'h7 >> (2'h3 - dead_time_prescale);
  assign dt_tick = timer_tick && ((dt_div & dt_mask) == dt_mask);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dt_div <= 3'h0;
    end else if (ce_i && timer_tick) begin
      dt_div <= dt_div + 3'h1;
    end
  end

  assign dt_cfg = '{rise: dead_time_reg[hs_timer_pkg::DT_HI_LSB +: 4],
                    fall: dead_time_reg[hs_timer_pkg::DT_LO_LSB +: 4],
                    invert: pwm_inversion_bit};

  // Channels A, B and D; slot 2 holds the top and has no output
  for (genvar i = 0; i < 3; i++) begin : g_ch
    localparam int S = (i == 2) ? 3 : i;
    logic [1:0] com;
    logic wave;
    logic dt_en;
    logic pwm_lvl;
    assign com = compare_output_mode[2*i +: 2];
    assign cmp_hit[i] = timer_tick && !match_block &&
                        (count_value == compare_active[S]);
    assign dt_en = channel_pwm_enable[i] &&
                   (com == hs_timer_pkg::COM_TOGGLE);
    // Level at a PWM match; mode 11 gives the inverted waveform
    assign pwm_lvl = (up_down && count_dir == hs_timer_pkg::DIR_DOWN) ^
                     (com == hs_timer_pkg::COM_SET);
    assign waveform_output[i] = wave;

    always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
        wave <= 1'b0;
      end else if (ce_i) begin
        if (!channel_pwm_enable[i]) begin
          if (cmp_hit[i] || force_compare_strobe[i]) begin
            wave <= com_level(com, wave);
          end
        end else if (com != hs_timer_pkg::COM_NONE) begin
          if (cmp_hit[i]) begin
            wave <= pwm_lvl;
          end
          if (timer_tick && !up_down && !cnt_wr && at_top) begin
            wave <= com != hs_timer_pkg::COM_SET;
          end
        end
      end
    end

    hs_dead_time u_dt (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .tick_i(timer_tick),
      .dt_tick_i(dt_tick),
      .enable_i(dt_en),
      .wave_i(wave),
      .cfg_i(dt_cfg),
      .oc_true_o(oc_true_o[i]),
      .oc_comp_o(oc_comp_o[i])
    );
  end

  always_comb begin
    rd_val = 8'h00;
    rd_hi = shared_high_byte_buffer;
    rd_latch = 1'b0;
    case (bus_req_i.addr)
      hs_timer_pkg::A_CNT_LO: begin
        rd_val = count_value[7:0];
        rd_hi = count_value[9:8];
        rd_latch = 1'b1;
      end
      hs_timer_pkg::A_HIGH_BUF: rd_val = {6'h00, shared_high_byte_buffer};
      hs_timer_pkg::A_CTRL_A: rd_val = {pwm_inversion_bit, waveform_gen_bit,
                                        dead_time_prescale, clock_select_field};
      hs_timer_pkg::A_CTRL_B: rd_val = {5'h00, channel_pwm_enable};
      hs_timer_pkg::A_COM: rd_val = {2'h0, compare_output_mode};
      hs_timer_pkg::A_DEAD: rd_val = dead_time_reg;
      hs_timer_pkg::A_FLAGS: rd_val = {4'h0, flags};
      hs_timer_pkg::A_IRQ_EN: rd_val = {4'h0, irq_enable};
      hs_timer_pkg::A_PLL: rd_val = {pll_lock_flag, 5'h00,
                                     fast_postscaler_field};
      default: begin
        for (int k = 0; k < 4; k++) begin
          if (bus_req_i.addr == slot_addr(k)) begin
            rd_val = compare_value_reg[k][7:0];
            rd_hi = compare_value_reg[k][9:8];
            rd_latch = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      shared_high_byte_buffer <= 2'h0;
    end else if (ce_i) begin
      if (wr_hit(bus_req_i, hs_timer_pkg::A_HIGH_BUF)) begin
        shared_high_byte_buffer <= bus_req_i.wdata[1:0];
      end else if (bus_req_i.rd && rd_latch) begin
        shared_high_byte_buffer <= rd_hi;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= bus_req_i.rd ? rd_val : 8'h00;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_bottom;
    ce_i && timer_tick && !cnt_wr && !up_down && at_top |=> bottom_o;
  endproperty
  a_bottom: assert property (p_bottom) else $error("no bottom after wrap");

  property p_stop;
    ce_i && clock_select_field == hs_timer_pkg::CS_STOP && !cnt_wr
      |=> $stable(count_value);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");

  property p_wr_prio;
    ce_i && cnt_wr |=> count_value == $past(wr_word);
  endproperty
  a_wr_prio: assert property (p_wr_prio) else $error("write lost");

  property p_flag_a;
    ce_i && timer_tick && !match_block &&
      count_value == compare_active[0] |=> flags[1];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("flag A not set");

  property p_block;
    (ce_i && cnt_wr) ##1 (ce_i && timer_tick && flags[3:1] == 3'h0)
      |=> flags[3:1] == 3'h0;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_force;
    ce_i && wr_hit(bus_req_i, hs_timer_pkg::A_CTRL_B) && !pwm_mode &&
      !timer_tick |=> $stable(count_value) && !$rose(flags[1]);
  endproperty
  a_force: assert property (p_force) else $error("force side effect");

  property p_buffered;
    ce_i && pwm_mode && wr_hit(bus_req_i, hs_timer_pkg::A_CMP_A) &&
      !buf_update |=> $stable(compare_active[0]) &&
      compare_value_reg[0] == $past(wr_word);
  endproperty
  a_buffered: assert property (p_buffered) else $error("bad buffering");

  property p_lag;
    ce_i && timer_tick && !channel_pwm_enable[0]
      |=> oc_true_o[0] == $past(waveform_output[0]);
  endproperty
  a_lag: assert property (p_lag) else $error("output lag wrong");

  property p_no_overlap;
    g_ch[0].dt_en |-> !((oc_true_o[0] ^ pwm_inversion_bit) &&
                        (oc_comp_o[0] ^ pwm_inversion_bit));
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("overlap");

  property p_hbuf;
    ce_i && bus_req_i.rd && bus_req_i.addr == hs_timer_pkg::A_CNT_LO
      |=> shared_high_byte_buffer == $past(count_value[9:8]);
  endproperty
  a_hbuf: assert property (p_hbuf) else $error("high byte not latched");

  c_ovf: cover property (ce_i && flag_set[0]);
  c_match: cover property (ce_i && flag_set[1]);
  c_update: cover property (ce_i && buf_update);
endmodule // hs_timer

/* verif/hs_cpu_model.sv */
/*
  CPU side model of the timer's register port: write, read and
  interrupt service tasks. Assumes the 50 MHz clock of the bench.
*/
`timescale 1ns/1ps
module hs_cpu_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output hs_timer_pkg::bus_req_s bus_o,
  output logic [3:0] int_ack_o,
  output logic pll_lock_o
);
  // Lock pin idles low until the bench raises it
  // Async clocking is not modelled; the postscaler is only stored
  initial begin
    bus_o = '0;
    int_ack_o = 4'h0;
    pll_lock_o = 1'b0;
  end

  // One strobe cycle, then idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_o <= '0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_o <= '0;
    #1 d = rdata_i;
  endtask

  // Lock pin level, changed just after an edge
  task automatic lock(input logic v);
    @(posedge clock_i);
    pll_lock_o <= v;
  endtask

  task automatic ack(input logic [3:0] m);
    @(posedge clock_i);
    int_ack_o <= m;
    @(posedge clock_i);
    int_ack_o <= 4'h0;
  endtask
endmodule // hs_cpu_model

/* verif/high_speed_timer_compare_deadtime_tb_top.sv */
/*
  Self-checking bench of the timer: counter access, stop, flags and
  forced compare. Assumes the CPU model drives the register port.
*/
`timescale 1ns/1ps
module high_speed_timer_compare_deadtime_tb_top;
  logic clock_i;
  logic sys_rst_i;
  logic ce_i;
  hs_timer_pkg::bus_req_s bus_req;
  logic [7:0] rdata;
  logic [3:0] int_ack;
  logic pll_lock;
  logic [3:0] irq;
  logic [2:0] oc_true;
  logic [2:0] oc_comp;
  logic bottom;
  logic max_flag;
  logic [7:0] d;
  int mismatches = 0;
  int tests_run = 0;

  hs_timer u_hs_timer (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .bus_req_i(bus_req), .rdata_o(rdata),
    .int_ack_i(int_ack), .pll_lock_i(pll_lock), .irq_o(irq),
    .oc_true_o(oc_true), .oc_comp_o(oc_comp), .bottom_o(bottom),
    .max_o(max_flag));
  hs_cpu_model u_hs_cpu_model (.clock_i(clock_i), .rdata_i(rdata),
    .bus_o(bus_req), .int_ack_o(int_ack), .pll_lock_o(pll_lock));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Reset values and ten-bit access through the shared buffer
  task automatic t_regs();
    u_hs_cpu_model.rd(hs_timer_pkg::A_TOP, d);
    chk(d, 8'hFF);
    chk({7'h00, bottom}, 8'h01);
    u_hs_cpu_model.wr(hs_timer_pkg::A_HIGH_BUF, 8'h03);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CNT_LO, 8'hFF);
    #1 chk({7'h00, max_flag}, 8'h01);
    u_hs_cpu_model.wr(hs_timer_pkg::A_HIGH_BUF, 8'h00);
    u_hs_cpu_model.rd(hs_timer_pkg::A_CNT_LO, d);
    chk(d, 8'hFF);
    u_hs_cpu_model.rd(hs_timer_pkg::A_HIGH_BUF, d);
    chk(d, 8'h03);
    // Lock flag goes through the three stage synchroniser
    u_hs_cpu_model.lock(1'b1);
    repeat (4) @(posedge clock_i);
    u_hs_cpu_model.rd(hs_timer_pkg::A_PLL, d);
    chk(d, 8'h80);
    u_hs_cpu_model.wr(hs_timer_pkg::A_PLL, 8'h01);
    u_hs_cpu_model.rd(hs_timer_pkg::A_PLL, d);
    chk(d, 8'h81);
  endtask

  // Compare A far above top, toggle mode, then force it
  task automatic t_force();
    u_hs_cpu_model.wr(hs_timer_pkg::A_HIGH_BUF, 8'h02);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CMP_A, 8'h00);
    u_hs_cpu_model.wr(hs_timer_pkg::A_COM, 8'h01);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_B, 8'h08);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_A, 8'h01);
    repeat (4) @(posedge clock_i);
    #1 chk({7'h00, oc_true[0]}, 8'h01);
    u_hs_cpu_model.rd(hs_timer_pkg::A_FLAGS, d);
    chk(d & 8'h02, 8'h00);
  endtask

  // Count written away from the compare value
  task automatic t_match();
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_A, 8'h00);
    u_hs_cpu_model.wr(hs_timer_pkg::A_HIGH_BUF, 8'h00);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CMP_A, 8'h20);
    u_hs_cpu_model.wr(hs_timer_pkg::A_IRQ_EN, 8'h02);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CNT_LO, 8'h10);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_A, 8'h01);
    repeat (24) @(posedge clock_i);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_A, 8'h00);
    #1 chk({4'h0, irq}, 8'h02);
    u_hs_cpu_model.ack(4'h2);
    #1 chk({4'h0, irq}, 8'h00);
  endtask

  // Fast PWM pair on A: rise nibble 2, compare buffered until top
  task automatic t_dead();
    u_hs_cpu_model.wr(hs_timer_pkg::A_DEAD, 8'h21);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CNT_LO, 8'h00);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_B, 8'h01);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CMP_A, 8'h40);
    u_hs_cpu_model.rd(hs_timer_pkg::A_CMP_A, d);
    chk(d, 8'h40);
    u_hs_cpu_model.wr(hs_timer_pkg::A_CTRL_A, 8'h01);
    repeat (100) @(posedge clock_i);
    #1 chk({6'h00, oc_true[0], oc_comp[0]}, 8'h01);
    repeat (158) @(posedge clock_i);
    #1 chk({6'h00, oc_true[0], oc_comp[0]}, 8'h00);
    @(posedge clock_i);
    #1 chk({6'h00, oc_true[0], oc_comp[0]}, 8'h02);
    repeat (45) @(posedge clock_i);
    #1 chk({6'h00, oc_true[0], oc_comp[0]}, 8'h02);
  endtask

  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_force();
    t_match();
    t_dead();
    results();
  end

  // Whole run needs a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule // high_speed_timer_compare_deadtime_tb_top
